// ---- design/limit_result_output_port.sv ----
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
// How it works
// (R1) Trigger input passes only while its enable pin is high or left open.
// (R2) Five lines: low1, high1, low2, high2, and the summary line.
// (R3) Summary line is the OR of the four limit failures.
// (R4) A line goes active on failure and releases on an in-limit reading.
// (R5) Lines update 10 ms after trigger with channel closure, else 2 ms.
// (R6) Temperature readings stretch that settling delay tenfold.
// (R7) Level select: active high drives failing lines high, else low.
// (R8) Pulse mode emits one timed active pulse per failing reading.
// (R9) Pulse length defaults to 2 ms, programmable 1 ms to 99999.999 s.
// (R10) Pulse timing never stalls readings; the reading port has no backpressure.
// (R11) An in-limit reading ends a running pulse at once.
// (R12) Without hold, the summary line releases when all four limits pass.
// (R13) With hold, summary stays active until control source is passed.
// (R14) While scanning, held summary releases only when a new scan starts.
// (R15) Global line enable releases all five lines when off.
// (R16) One global output configuration serves every scanned channel.
// (R17) Overflow counts as positive: high failures only, never low.
// (R18) Limits compare the processed result supplied by the math stage.
// (R19) High fails at value >= bound; low fails at value <= bound.
// (R20) All timing runs off one clock with a derived millisecond tick.
module limit_result_output_port #(
	parameter int MS_CYCLES = limit_result_pkg::MS_CYCLES
) (
	// Clock and reset
	input  wire logic        I_CLK,
	input  wire logic        I_RST_N,
	// Register port
	input  wire logic [7:0]  I_ADDR,
	input  wire logic [31:0] I_WDATA,
	input  wire logic        I_WR,
	input  wire logic        I_RD,
	output logic      [31:0] O_RDATA,
	// Processed readings from the math stage
	input  wire logic        I_READING_VALID,
	input  wire logic [31:0] I_READING_VALUE,
	input  wire logic        I_READING_OVERFLOW,
	input  wire logic        I_CHANNEL_CLOSED,
	input  wire logic        I_TEMPERATURE,
	// Trigger sequencer
	input  wire logic        I_OUTPUT_TRIGGER_EVENT,
	input  wire logic        I_CONTROL_SOURCE_PASS,
	input  wire logic        I_SCANNING,
	input  wire logic        I_SCAN_START,
	// External trigger input
	input  wire logic        I_TRIG_IN,
	input  wire logic        I_TRIG_ENABLE,
	output logic             O_TRIG_ACCEPTED,
	// Result lines (open collector)
	output logic      [4:0]  O_RESULT_LINE,
	output logic      [4:0]  O_RESULT_OE_N
);

	localparam int PW = limit_result_pkg::PULSE_W;
	localparam int MSW = $clog2(MS_CYCLES + 1);

	typedef struct packed {
		logic [3:0]        ctrl;
		logic [PW-1:0]     pulse_ms;
		logic [3:0][31:0]  bound;
		logic [3:0]        pending;
		logic [7:0]        settle_left;
		logic              settle_busy;
		logic              apply;
		logic [MSW-1:0]    ms_count;
		logic              ms_tick;
		logic              held;
		logic [4:0]        line;
		logic [4:0]        oe_n;
		logic              trig;
		logic [31:0]       rdata;
	} port_state_t;

	port_state_t st_reg;
	port_state_t st_next;
	logic [4:0]  active;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Failure pair for one bound set: {high, low}
	function automatic logic [1:0] limit_fail(
		input logic [31:0] value,
		input logic        ovf,
		input logic [31:0] low,
		input logic [31:0] high
	);
		logic hi_f;
		logic lo_f;
		hi_f = ovf | ($signed(value) >= $signed(high)); // (R17) (R19)
		lo_f = ~ovf & ($signed(value) <= $signed(low)); // (R17) (R19)
		return {hi_f, lo_f};
	endfunction

	// Keep pulse length inside its programmable range
	// A zero length would end a pulse before it starts, so it is raised to the minimum
	function automatic logic [PW-1:0] clamp_pulse(input logic [31:0] v);
		logic [PW-1:0] r;
		if (v > 32'(limit_result_pkg::PULSE_MAX_MS)) begin
			r = limit_result_pkg::PULSE_MAX_MS;
		end else if (v < 32'(limit_result_pkg::PULSE_MIN_MS)) begin
			r = limit_result_pkg::PULSE_MIN_MS;
		end else begin
			r = v[PW-1:0];
		end
		return r;
	endfunction

	// Settling delay in milliseconds for the reading now pending
	function automatic logic [7:0] settle_ms(input logic closed, input logic temp);
		logic [7:0] base;
		base = closed ? limit_result_pkg::SETTLE_CLOSE_MS : limit_result_pkg::SETTLE_OPEN_MS; // (R5)
		return temp ? 8'(base * limit_result_pkg::TEMP_FACTOR) : base; // (R6)
	endfunction

	// ------------------------------------------------------------
	// Result line engines
	// ------------------------------------------------------------
	// Four limit lines plus the summary, all on one global configuration
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : g_line
			logic fail_bit;
			if (gi < 4) begin : g_limit
				assign fail_bit = st_reg.pending[gi];
			end else begin : g_summary
				assign fail_bit = |st_reg.pending; // (R3)
			end
			result_line_pulser #(
				.W          (PW)
			) u_pulser (
				.i_clk      (I_CLK),
				.i_rst_n    (I_RST_N),
				.i_ms_tick  (st_reg.ms_tick),
				.i_apply    (st_reg.apply),
				.i_fail     (fail_bit),
				.i_pulse_en (st_reg.ctrl[limit_result_pkg::BIT_PULSE_EN]), // (R16)
				.i_pulse_ms (st_reg.pulse_ms),
				.o_active   (active[gi])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic [1:0] f1;
		logic [1:0] f2;
		logic [4:0] act;
		logic       lvl;
		st_next = st_reg;
		// Temporaries start from known values so no stale level is ever read
		act = 5'h00;
		lvl = 1'b0;
		f1 = limit_fail(I_READING_VALUE, I_READING_OVERFLOW, st_reg.bound[0], st_reg.bound[1]);
		f2 = limit_fail(I_READING_VALUE, I_READING_OVERFLOW, st_reg.bound[2], st_reg.bound[3]);

		// Millisecond timebase shared by settling and pulses
		st_next.ms_tick = 1'b0;
		if (st_reg.ms_count >= MSW'(MS_CYCLES - 1)) begin
			st_next.ms_count = '0;
			st_next.ms_tick  = 1'b1; // (R20)
		end else begin
			st_next.ms_count = st_reg.ms_count + MSW'(1);
		end

		// Capture failures of each processed reading; the port never stalls it
		if (I_READING_VALID) begin
			st_next.pending = {f2[1], f2[0], f1[1], f1[0]}; // (R2) (R18) (R10)
		end

		// Settling: lines change only once the delay after the trigger is over
		// The first millisecond is partial, so the wait may run up to one tick short
		st_next.apply = 1'b0;
		if (st_reg.settle_busy && st_reg.ms_tick) begin
			if (st_reg.settle_left <= 8'h01) begin
				st_next.settle_busy = 1'b0;
				st_next.apply       = 1'b1; // (R5)
			end else begin
				st_next.settle_left = st_reg.settle_left - 8'h01;
			end
		end
		// A newer trigger restarts the wait for the newer reading
		if (I_OUTPUT_TRIGGER_EVENT) begin
			st_next.settle_busy = 1'b1;
			st_next.settle_left = settle_ms(I_CHANNEL_CLOSED, I_TEMPERATURE); // (R5) (R6)
			st_next.apply       = 1'b0;
		end

		// Summary hold: release on sequencer pass, or only on scan start while scanning
		if (I_SCAN_START || (I_CONTROL_SOURCE_PASS && !I_SCANNING)) begin
			st_next.held = 1'b0; // (R13) (R14)
		end
		if (!st_reg.ctrl[limit_result_pkg::BIT_HOLD_EN]) begin
			st_next.held = 1'b0; // (R12)
		end
		// Set wins over a release in the same cycle
		if (st_reg.apply && (|st_reg.pending) && st_reg.ctrl[limit_result_pkg::BIT_HOLD_EN]) begin
			st_next.held = 1'b1; // (R13)
		end

		// Line levels: active state, level select and global enable
		act = {active[4] | st_reg.held, active[3:0]}; // (R12) (R13)
		lvl = st_reg.ctrl[limit_result_pkg::BIT_LEVEL_HIGH];
		st_next.line = lvl ? act : ~act; // (R7)
		st_next.oe_n = st_reg.ctrl[limit_result_pkg::BIT_LINES_EN] ? 5'h00 : 5'h1f; // (R15)

		// External trigger passes only with its enable held high or open
		st_next.trig = I_TRIG_IN & I_TRIG_ENABLE; // (R1)

		// Register writes
		// Status is read-only; a write to its offset falls to the default and is dropped
		if (I_WR) begin
			unique case (I_ADDR)
				limit_result_pkg::OFS_CTRL: begin
					st_next.ctrl = I_WDATA[3:0]; // (R16)
				end
				limit_result_pkg::OFS_PULSE_MS: begin
					st_next.pulse_ms = clamp_pulse(I_WDATA); // (R9)
				end
				limit_result_pkg::OFS_LOW1: begin
					st_next.bound[0] = I_WDATA;
				end
				limit_result_pkg::OFS_HIGH1: begin
					st_next.bound[1] = I_WDATA;
				end
				limit_result_pkg::OFS_LOW2: begin
					st_next.bound[2] = I_WDATA;
				end
				limit_result_pkg::OFS_HIGH2: begin
					st_next.bound[3] = I_WDATA;
				end
				default: begin
				end
			endcase
		end

		// Register reads: data stand in the following cycle only
		st_next.rdata = 32'h00000000;
		if (I_RD) begin
			unique case (I_ADDR)
				limit_result_pkg::OFS_CTRL: begin
					st_next.rdata = {28'h0000000, st_reg.ctrl};
				end
				limit_result_pkg::OFS_PULSE_MS: begin
					st_next.rdata = 32'(st_reg.pulse_ms);
				end
				limit_result_pkg::OFS_LOW1: begin
					st_next.rdata = st_reg.bound[0];
				end
				limit_result_pkg::OFS_HIGH1: begin
					st_next.rdata = st_reg.bound[1];
				end
				limit_result_pkg::OFS_LOW2: begin
					st_next.rdata = st_reg.bound[2];
				end
				limit_result_pkg::OFS_HIGH2: begin
					st_next.rdata = st_reg.bound[3];
				end
				// Active bits are taken before level select and line enable
				limit_result_pkg::OFS_STATUS: begin
					st_next.rdata[limit_result_pkg::POS_ACTIVE +: 5]  = act;
					st_next.rdata[limit_result_pkg::POS_PENDING +: 4] = st_reg.pending;
					st_next.rdata[limit_result_pkg::BIT_SETTLE]       = st_reg.settle_busy;
					st_next.rdata[limit_result_pkg::BIT_HELD]         = st_reg.held;
				end
				default: begin
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			st_reg          <= '0;
			st_reg.ctrl     <= limit_result_pkg::RST_CTRL;
			st_reg.pulse_ms <= limit_result_pkg::PULSE_DEFAULT_MS; // (R9)
			st_reg.bound[0] <= limit_result_pkg::RST_LOW1;
			st_reg.bound[1] <= limit_result_pkg::RST_HIGH1;
			st_reg.bound[2] <= limit_result_pkg::RST_LOW2;
			st_reg.bound[3] <= limit_result_pkg::RST_HIGH2;
			st_reg.line     <= 5'h00;
			st_reg.oe_n     <= 5'h1f; // Lines released until enabled
		end else begin
			st_reg <= st_next;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Every pin comes straight from a flip-flop, so a decode never glitches a line
	assign O_RDATA         = st_reg.rdata;
	assign O_TRIG_ACCEPTED = st_reg.trig;
	assign O_RESULT_LINE   = st_reg.line;
	assign O_RESULT_OE_N   = st_reg.oe_n;

endmodule // limit_result_output_port

// ---- design/limit_result_pkg.sv ----
package limit_result_pkg;

	// ------------------------------------------------------------
	// Register offsets (byte addresses, one word each)
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL      = 8'h00;
	localparam logic [7:0] OFS_PULSE_MS  = 8'h04;
	localparam logic [7:0] OFS_LOW1      = 8'h08;
	localparam logic [7:0] OFS_HIGH1     = 8'h0c;
	localparam logic [7:0] OFS_LOW2      = 8'h10;
	localparam logic [7:0] OFS_HIGH2     = 8'h14;
	localparam logic [7:0] OFS_STATUS    = 8'h18;

	// ------------------------------------------------------------
	// Control register fields
	// ------------------------------------------------------------
	localparam int BIT_LINES_EN   = 0;
	localparam int BIT_PULSE_EN   = 1;
	localparam int BIT_LEVEL_HIGH = 2;
	localparam int BIT_HOLD_EN    = 3;

	// ------------------------------------------------------------
	// Status register fields
	// ------------------------------------------------------------
	localparam int POS_ACTIVE  = 0;
	localparam int POS_PENDING = 5;
	localparam int BIT_SETTLE  = 10;
	localparam int BIT_HELD    = 11;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [3:0]  RST_CTRL  = 4'h4;
	localparam logic [31:0] RST_LOW1  = 32'hffffffff;
	localparam logic [31:0] RST_HIGH1 = 32'h00000001;
	localparam logic [31:0] RST_LOW2  = 32'hfffffffe;
	localparam logic [31:0] RST_HIGH2 = 32'h00000002;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS   = 5;
	localparam int MS_PERIOD_NS    = 1000000;
	localparam int MS_CYCLES       = MS_PERIOD_NS / CLK_PERIOD_NS;
	localparam logic [7:0] SETTLE_CLOSE_MS = 8'h0a;
	localparam logic [7:0] SETTLE_OPEN_MS  = 8'h02;
	localparam logic [7:0] TEMP_FACTOR     = 8'h0a;
	localparam int PULSE_W = 27;
	localparam logic [PULSE_W-1:0] PULSE_DEFAULT_MS = 27'h0000002;
	localparam logic [PULSE_W-1:0] PULSE_MIN_MS     = 27'h0000001;
	localparam logic [PULSE_W-1:0] PULSE_MAX_MS     = 27'h5f5e0ff;

endpackage

// ---- design/result_line_pulser.sv ----
`timescale 1ns/1ps
// One result line: steady level or a timed pulse, cut short by a pass
module result_line_pulser #(
	parameter int W = 27
) (
	// Clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_rst_n,
	// Timing and commit
	input  wire logic         i_ms_tick,
	input  wire logic         i_apply,
	input  wire logic         i_fail,
	// Configuration
	input  wire logic         i_pulse_en,
	input  wire logic [W-1:0] i_pulse_ms,
	// Result
	output logic              o_active
);

	typedef struct packed {
		logic         active;
		logic         timed;
		logic [W-1:0] left;
	} pulser_state_t;

	pulser_state_t st_reg;
	pulser_state_t st_next;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	// Timing runs beside the reading path and never holds it up
	always_comb begin
		st_next = st_reg;
		if (st_reg.timed && i_ms_tick) begin
			if (st_reg.left <= W'(1)) begin
				st_next.active = 1'b0;
				st_next.timed  = 1'b0;
			end else begin
				st_next.left = st_reg.left - W'(1);
			end
		end
		if (i_apply) begin
			if (i_fail) begin
				st_next.active = 1'b1; // (R4)
				st_next.timed  = i_pulse_en; // (R8)
				st_next.left   = i_pulse_ms;
			end else begin
				st_next.active = 1'b0; // (R11)
				st_next.timed  = 1'b0;
			end
		end
	end

	// State register
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_active = st_reg.active;

endmodule // result_line_pulser

// ---- dv/result_line_load.sv ----
`timescale 1ns/1ps
// ----
// External relays and logic inputs on the result lines
// ----
module result_line_load (
	// From the block
	input  wire logic [4:0] i_line,
	input  wire logic [4:0] i_oe_n,
	// Test control of the enable pin
	input  wire logic       i_pull_low,
	// Levels seen at the pins
	output logic      [4:0] o_level,
	output logic            o_trig_enable
);
	// Built-in pull-up wins wherever the driver is off
	assign o_level = (i_line & ~i_oe_n) | i_oe_n;
	// Enable pin floats high unless the load ties it low
	assign o_trig_enable = !i_pull_low;
endmodule // result_line_load

// ---- dv/limit_result_props.sv ----
`timescale 1ns/1ps
// ----
// Port checker
// ----
module limit_result_props #(
	parameter int MS_CYCLES = limit_result_pkg::MS_CYCLES
) (
	// Clock, reset, register port
	input wire logic        I_CLK,
	input wire logic        I_RST_N,
	input wire logic [7:0]  I_ADDR,
	input wire logic [31:0] I_WDATA,
	input wire logic        I_WR,
	input wire logic        I_RD,
	input wire logic [31:0] O_RDATA,
	// Trigger paths
	input wire logic        I_OUTPUT_TRIGGER_EVENT,
	input wire logic        I_TRIG_IN,
	input wire logic        I_TRIG_ENABLE,
	input wire logic        O_TRIG_ACCEPTED,
	// Result lines
	input wire logic [4:0]  O_RESULT_LINE,
	input wire logic [4:0]  O_RESULT_OE_N
);
	logic [31:0] since_reg;
	logic [2:0]  wr_reg;
	logic        lvl_reg;
	// Cycles since the last trigger; wide enough for a full-scale millisecond
	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			since_reg <= 32'hffffffff;
			wr_reg    <= 3'h0;
			lvl_reg   <= limit_result_pkg::RST_CTRL[limit_result_pkg::BIT_LEVEL_HIGH];
		end else begin
			wr_reg <= {wr_reg[1:0], I_WR};
			// Track level select so only moves toward the active level are timed
			if (I_WR && I_ADDR == limit_result_pkg::OFS_CTRL)
				lvl_reg <= I_WDATA[limit_result_pkg::BIT_LEVEL_HIGH];
			if (I_OUTPUT_TRIGGER_EVENT)
				since_reg <= 32'h00000000;
			else if (since_reg != 32'hffffffff)
				since_reg <= since_reg + 32'h00000001;
		end
	end
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RST_N);
	// Lines may turn active only one millisecond or more after a trigger, or after a control write; pulse ends may come any time
	a_settle_min: assert property ((lvl_reg ? |(O_RESULT_LINE & ~$past(O_RESULT_LINE))
		: |(~O_RESULT_LINE & $past(O_RESULT_LINE))) && wr_reg == 3'h0 |-> since_reg >= MS_CYCLES)
		else $error("result line turned active before settling");
	a_trig_pass: assert property (I_TRIG_IN && I_TRIG_ENABLE |=> O_TRIG_ACCEPTED)
		else $error("enabled trigger not accepted");
	a_trig_block: assert property (!I_TRIG_ENABLE |=> !O_TRIG_ACCEPTED)
		else $error("disabled trigger accepted");
	a_oe_uniform: assert property (O_RESULT_OE_N == 5'h00 || O_RESULT_OE_N == 5'h1f)
		else $error("lines not enabled together");
	a_oe_by_write: assert property ($changed(O_RESULT_OE_N) |-> $past(I_WR, 2) && $past(I_ADDR, 2) == 8'h00)
		else $error("line enable moved without control write");
	a_oe_after_reset: assert property ($rose(I_RST_N) |-> O_RESULT_OE_N == 5'h1f)
		else $error("lines driven after reset");
	a_pulse_range: assert property (I_RD && I_ADDR == 8'h04 |=> O_RDATA >= 32'h1 && O_RDATA <= 32'h05f5e0ff)
		else $error("pulse length out of range");
	a_rdata_idle: assert property (!I_RD |=> O_RDATA == 32'h0)
		else $error("read data outside read cycle");
	a_unmapped_zero: assert property (I_RD && I_ADDR > 8'h18 |=> O_RDATA == 32'h0)
		else $error("unmapped read not zero");
	c_trigger: cover property (I_OUTPUT_TRIGGER_EVENT);
	c_enable: cover property ($fell(O_RESULT_OE_N[4]));
	c_summary: cover property ($changed(O_RESULT_LINE[4]));
endmodule // limit_result_props

bind limit_result_output_port limit_result_props #(.MS_CYCLES(MS_CYCLES)) limit_result_props_i (
	.I_CLK(I_CLK),
	.I_RST_N(I_RST_N),
	.I_ADDR(I_ADDR),
	.I_WDATA(I_WDATA),
	.I_WR(I_WR),
	.I_RD(I_RD),
	.O_RDATA(O_RDATA),
	.I_OUTPUT_TRIGGER_EVENT(I_OUTPUT_TRIGGER_EVENT),
	.I_TRIG_IN(I_TRIG_IN),
	.I_TRIG_ENABLE(I_TRIG_ENABLE),
	.O_TRIG_ACCEPTED(O_TRIG_ACCEPTED),
	.O_RESULT_LINE(O_RESULT_LINE),
	.O_RESULT_OE_N(O_RESULT_OE_N)
);

// ---- dv/test_limit_result_output_port.sv ----
`timescale 1ns/1ps
module test_limit_result_output_port;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [31:0] rdata;
	logic [31:0] val = 32'h0;
	logic        vld = 1'b0;
	logic        ovf = 1'b0;
	logic        cls = 1'b0;
	logic        tmp = 1'b0;
	logic        trg = 1'b0;
	logic        pas = 1'b0;
	logic        scn = 1'b0;
	logic        sst = 1'b0;
	logic        tin = 1'b0;
	logic        pull_low = 1'b0;
	logic        ten;
	logic        tacc;
	logic [4:0]  line;
	logic [4:0]  oen;
	logic [4:0]  lvl;
	int          err_total = 0;
	int          checks = 0;
	// Settling counts shortened to 20 cycles per millisecond
	limit_result_output_port #(.MS_CYCLES(20)) limit_result_output_port_i (
		.I_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
		.O_RDATA(rdata), .I_READING_VALID(vld), .I_READING_VALUE(val), .I_READING_OVERFLOW(ovf),
		.I_CHANNEL_CLOSED(cls), .I_TEMPERATURE(tmp), .I_OUTPUT_TRIGGER_EVENT(trg),
		.I_CONTROL_SOURCE_PASS(pas), .I_SCANNING(scn), .I_SCAN_START(sst), .I_TRIG_IN(tin),
		.I_TRIG_ENABLE(ten), .O_TRIG_ACCEPTED(tacc), .O_RESULT_LINE(line), .O_RESULT_OE_N(oen)
	);
	result_line_load result_line_load_i (
		.i_line(line), .i_oe_n(oen), .i_pull_low(pull_low), .o_level(lvl), .o_trig_enable(ten)
	);
	// ----
	// Shared tasks
	// ----
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic line_is(input logic [4:0] e);
		chk({27'h0, lvl}, {27'h0, e});
	endtask
	task automatic after(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic bus_rd(input logic [7:0] a, output logic [31:0] q);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 q = rdata;
	endtask
	// One reading, then its output trigger, then a wait of n cycles
	task automatic shot(input logic [31:0] v, input logic o, c, t, input int n);
		@(posedge clk);
		vld <= 1'b1;
		val <= v;
		ovf <= o;
		@(posedge clk);
		vld <= 1'b0;
		trg <= 1'b1;
		cls <= c;
		tmp <= t;
		@(posedge clk);
		trg <= 1'b0;
		after(n);
	endtask
	// Bounded wait for a line pattern; pulse start time is not fixed
	task automatic wait_for(input logic [4:0] e);
		for (int i = 0; i < 100 && lvl !== e; i++)
			@(negedge clk);
	endtask
	task automatic seq(input logic s, p, t);
		@(posedge clk);
		scn <= s;
		pas <= p;
		sst <= t;
		@(posedge clk);
		pas <= 1'b0;
		sst <= 1'b0;
		after(4);
	endtask
	// ----
	// Scenarios
	// ----
	task automatic t_regs();
		logic [31:0] q;
		logic [31:0] bnd [4] = '{32'hffffffff, 32'h1, 32'hfffffffe, 32'h2};
		after(1);
		line_is(5'h1f);
		bus_rd(8'h00, q);
		chk(q, 32'h4);
		bus_rd(8'h04, q);
		chk(q, 32'h2);
		for (int i = 0; i < 4; i++) begin
			bus_rd(8'h08 + 8'(4 * i), q);
			chk(q, bnd[i]);
		end
		bus_rd(8'h40, q);
		chk(q, 32'h0);
		bus_wr(8'h04, 32'h0);
		bus_rd(8'h04, q);
		chk(q, 32'h1);
		bus_wr(8'h04, 32'hffffffff);
		bus_rd(8'h04, q);
		chk(q, 32'h05f5e0ff);
	endtask
	task automatic t_trig();
		@(posedge clk);
		tin <= 1'b1;
		after(2);
		chk({31'h0, tacc}, 32'h1);
		@(posedge clk);
		pull_low <= 1'b1;
		after(2);
		chk({31'h0, tacc}, 32'h0);
		@(posedge clk);
		tin <= 1'b0;
		pull_low <= 1'b0;
	endtask
	// Level mode at boundary values, overflow, then disable and low sense
	task automatic t_level();
		bus_wr(8'h00, 32'h5);
		shot(32'h1, 1'b0, 1'b0, 1'b0, 46);
		line_is(5'h12);
		shot(32'h0, 1'b0, 1'b0, 1'b0, 46);
		line_is(5'h00);
		shot(32'h80000000, 1'b1, 1'b0, 1'b0, 46);
		line_is(5'h1a);
		shot(32'hfffffffe, 1'b0, 1'b0, 1'b0, 46);
		line_is(5'h15);
		bus_wr(8'h00, 32'h4);
		after(3);
		line_is(5'h1f);
		bus_wr(8'h00, 32'h1);
		after(3);
		line_is(5'h0a);
		shot(32'h0, 1'b0, 1'b0, 1'b0, 46);
		line_is(5'h1f);
	endtask
	task automatic t_delay();
		bus_wr(8'h00, 32'h5);
		shot(32'h1, 1'b0, 1'b1, 1'b0, 178);
		line_is(5'h00);
		after(28);
		line_is(5'h12);
		shot(32'h0, 1'b0, 1'b0, 1'b1, 370);
		line_is(5'h12);
		after(36);
		line_is(5'h00);
	endtask
	task automatic t_pulse();
		bus_wr(8'h00, 32'h7);
		bus_wr(8'h04, 32'h2);
		shot(32'h1, 1'b0, 1'b0, 1'b0, 0);
		wait_for(5'h12);
		after(10);
		line_is(5'h12);
		after(40);
		line_is(5'h00);
		bus_wr(8'h04, 32'd100);
		shot(32'h1, 1'b0, 1'b0, 1'b0, 0);
		wait_for(5'h12);
		line_is(5'h12);
		shot(32'h0, 1'b0, 1'b0, 1'b0, 46);
		line_is(5'h00);
	endtask
	task automatic t_hold();
		logic [31:0] q;
		bus_wr(8'h00, 32'hd);
		shot(32'h1, 1'b0, 1'b0, 1'b0, 46);
		shot(32'h0, 1'b0, 1'b0, 1'b0, 46);
		line_is(5'h10);
		bus_rd(8'h18, q);
		chk(q, 32'h00000810);
		seq(1'b1, 1'b1, 1'b0);
		line_is(5'h10);
		seq(1'b1, 1'b0, 1'b1);
		line_is(5'h00);
		shot(32'h1, 1'b0, 1'b0, 1'b0, 46);
		shot(32'h0, 1'b0, 1'b0, 1'b0, 46);
		seq(1'b0, 1'b1, 1'b0);
		line_is(5'h00);
	endtask
	// ----
	// Run control
	// ----
	task automatic summarize();
		$display("checks %0d errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		forever #2.5 clk = ~clk;
	end
	// Whole run needs about 1300 cycles; allow just over thirty times that
	initial begin
		#200000;
		err_total++;
		summarize();
	end
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_trig();
		t_level();
		t_delay();
		t_pulse();
		t_hold();
		summarize();
	end
endmodule // test_limit_result_output_port
